/* File: verilog/atoc_pkg.sv */
// package: register map, fields and timing constants for the tuning and calibration control block
//
// Behaviour
// R1: tuning register bit 7 sends the divided antenna resonance onto the interrupt pin.
// R2: tuning register bits 3 to 0 select the antenna tuning capacitors.
// R3: a two-bit divider field picks ratio 16, 32, 64 or 128 for the antenna frequency.
// R4: the controller tunes the capacitors until the resonance is within 3.5 percent.
// R5: the system oscillator runs near 1.1 MHz and clocks all the digital logic; the code clocks its logic on sys_clk and only samples osc.sys.
// R6: a low-power timer oscillator runs alongside at a nominal 32.768 kHz.
// R7: bit 5 routes the timer oscillator, bit 6 the system oscillator, to the pin.
// R8: the calibration command trims both oscillators against the antenna resonance.
// R9: the controller should tune the antenna before it calibrates the oscillators.
// R10: calibration results are volatile, lost at power-on reset, and must be redone.
// R11: after power-down: command, set bit 5, wait 2 ms, clear bit 5.
// R12: with no display selected the pin is the event interrupt, cleared by a read.
// R13: the controller selects at most one display bit and clears them afterwards.
package atoc_pkg;
  localparam logic [7:0] ADDR_INT_DIV = 8'h03;
  localparam logic [7:0] ADDR_TUNE = 8'h08;
  localparam logic [7:0] ADDR_CAL_CMD = 8'h3D;
  localparam logic [7:0] CAL_CMD_CODE = 8'h96;
  localparam logic [7:0] ADDR_CAL_STAT = 8'h3A;
  localparam int TUNE_ANT_BIT = 7;
  localparam int TUNE_SYS_BIT = 6;
  localparam int TUNE_TMR_BIT = 5;
  localparam int DIV_LSB = 6;
  localparam int INT_DIST_MASK_BIT = 5;
  localparam logic [7:0] TUNE_RESET = 8'h00;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam int CAP_W = 4;
  localparam int TRIM_W = 7;
  localparam int CAL_WINDOW_US = 100;
  localparam int CLK_MHZ = 250;
  localparam int CAL_WINDOW_CYC = CAL_WINDOW_US * CLK_MHZ;
  localparam logic [TRIM_W-1:0] TRIM_MID = 7'h40;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } atoc_bus_t;

  typedef struct packed {
    logic ant;
    logic sys;
    logic tmr;
  } atoc_osc_t;
endpackage : atoc_pkg

/* File: verilog/atoc_trim.sv */
// trim search for one oscillator: counts its edges over a reference window and steps the trim
`timescale 1ns/1ps
module atoc_trim #(
  parameter int TRIM_W = 7,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  // measurement
  input wire logic osc_edge,
  input wire logic win_end,
  input wire logic run,
  input wire logic [CNT_W-1:0] target,
  // result
  output logic [TRIM_W-1:0] trim_r,
  output logic fast_r
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= '0;
    else if (ce)
    begin
      if (!run || win_end)
        cnt_r <= '0;
      else if (osc_edge)
        cnt_r <= cnt_r + 1'b1;
    end
  end

  // one step per window: slow drift search keeps it simple at the cost of many windows
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trim_r <= atoc_pkg::TRIM_MID; // see R10
      fast_r <= 1'b0;
    end
    else if (ce && run && win_end)
    begin
      fast_r <= (cnt_r > target);
      if (cnt_r > target && trim_r != '0)
        trim_r <= trim_r - 1'b1; // see R8
      else if (cnt_r < target && trim_r != '1)
        trim_r <= trim_r + 1'b1;
    end
  end
endmodule : atoc_trim

/* File: verilog/atoc_top.sv */
// tuning, frequency display routing and oscillator calibration control
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module atoc_top #(
  parameter int CAL_WINDOW_CYC = atoc_pkg::CAL_WINDOW_CYC,
  parameter int CAL_STEPS = 64,
  parameter logic [15:0] SYS_TARGET = 16'h0226,
  parameter logic [15:0] TMR_TARGET = 16'h0010
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire atoc_pkg::atoc_bus_t bus,
  output logic [7:0] rdata_r,
  // oscillator and antenna samples
  input wire atoc_pkg::atoc_osc_t osc,
  // event interrupt from the detection logic
  input wire logic event_irq,
  input wire logic [3:0] event_code,
  // analog controls and calibration status
  output logic [atoc_pkg::CAP_W-1:0] tune_cap,
  output logic [atoc_pkg::TRIM_W-1:0] sys_trim,
  output logic [atoc_pkg::TRIM_W-1:0] tmr_trim,
  output logic cal_busy,
  // interrupt pin
  output logic irq_pin
);
  typedef enum {ST_IDLE, ST_CAL, ST_DONE} atoc_state_t;

  atoc_state_t state_r;
  logic [7:0] tune_r;
  logic [1:0] div_r;
  logic dist_mask_r;
  logic [3:0] int_code_r;
  logic irq_r;
  logic [6:0] div_cnt_r;
  logic ant_q_r, sys_q_r, tmr_q_r;
  logic [31:0] win_cnt_r;
  logic [7:0] step_r;
  logic cal_ok_r;
  logic win_end;
  logic run;
  logic ant_rise, sys_rise, tmr_rise;
  logic div_out;
  logic sys_fast, tmr_fast;
  logic cal_cmd;

  assign ant_rise = osc.ant & ~ant_q_r;
  assign sys_rise = osc.sys & ~sys_q_r;
  assign tmr_rise = osc.tmr & ~tmr_q_r;
  assign cal_cmd = bus.wr && bus.addr == atoc_pkg::ADDR_CAL_CMD
                   && bus.wdata == atoc_pkg::CAL_CMD_CODE;
  assign run = (state_r == ST_CAL);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ant_q_r <= 1'b0;
      sys_q_r <= 1'b0;
      tmr_q_r <= 1'b0;
    end
    else if (ce)
    begin
      ant_q_r <= osc.ant;
      sys_q_r <= osc.sys;
      tmr_q_r <= osc.tmr;
    end
  end

  // register writes
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tune_r <= atoc_pkg::TUNE_RESET;
      div_r <= atoc_pkg::DIV_RESET;
      dist_mask_r <= 1'b0;
    end
    else if (ce && bus.wr)
    begin
      if (bus.addr == atoc_pkg::ADDR_TUNE)
        tune_r <= bus.wdata; // see R2
      // divider taken from the interrupt register's top bits
      if (bus.addr == atoc_pkg::ADDR_INT_DIV)
      begin
        div_r <= bus.wdata[atoc_pkg::DIV_LSB+1:atoc_pkg::DIV_LSB]; // see R3
        dist_mask_r <= bus.wdata[atoc_pkg::INT_DIST_MASK_BIT];
      end
    end
  end

  assign tune_cap = tune_r[atoc_pkg::CAP_W-1:0]; // see R2

  // antenna divider: toggles every 8, 16, 32 or 64 rising edges
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      div_cnt_r <= '0;
    else if (ce && ant_rise)
      div_cnt_r <= div_cnt_r + 1'b1; // see R3
  end

  always_comb
  begin
    case (div_r)
      2'h0: div_out = div_cnt_r[3];
      2'h1: div_out = div_cnt_r[4];
      2'h2: div_out = div_cnt_r[5];
      default: div_out = div_cnt_r[6];
    endcase
  end

  // event interrupt; a new event wins over the read that clears it
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_r <= 1'b0;
      int_code_r <= '0;
    end
    else if (ce)
    begin
      if (event_irq && !(dist_mask_r && event_code == 4'h4))
      begin
        irq_r <= 1'b1; // see R12
        int_code_r <= event_code;
      end
      else if (bus.rd && bus.addr == atoc_pkg::ADDR_INT_DIV)
        irq_r <= 1'b0; // see R12
    end
  end

  // pin mux, priority antenna, system, timer, then interrupt
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      irq_pin <= 1'b0;
    else if (ce)
    begin
      if (tune_r[atoc_pkg::TUNE_ANT_BIT])
        irq_pin <= div_out; // see R1
      else if (tune_r[atoc_pkg::TUNE_SYS_BIT])
        irq_pin <= osc.sys; // see R7
      else if (tune_r[atoc_pkg::TUNE_TMR_BIT])
        irq_pin <= osc.tmr; // see R7 R6 R11
      else
        irq_pin <= irq_r; // see R12
    end
  end

  // calibration sequencer
  // window closes on the antenna edge that completes it, so sequencer and trims see one span
  assign win_end = run && ant_rise && (win_cnt_r == 32'(CAL_WINDOW_CYC - 1));

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      win_cnt_r <= '0;
      step_r <= '0;
      cal_ok_r <= 1'b0; // see R10
    end
    else if (ce)
    begin
      case (state_r)
        ST_IDLE:
          if (cal_cmd)
          begin
            state_r <= ST_CAL; // see R8
            win_cnt_r <= '0;
            step_r <= '0;
            cal_ok_r <= 1'b0;
          end
        ST_CAL:
        begin
          // reference window is counted in antenna edges, so antenna accuracy sets trim accuracy
          if (ant_rise)
            win_cnt_r <= win_cnt_r + 1'b1;
          if (win_end)
          begin
            win_cnt_r <= '0;
            step_r <= step_r + 1'b1;
            if (step_r == 8'(CAL_STEPS - 1))
              state_r <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          cal_ok_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign cal_busy = run;

  atoc_trim #(.TRIM_W(atoc_pkg::TRIM_W), .CNT_W(16)) u_sys_trim (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .osc_edge(sys_rise),
    .win_end(win_end),
    .run(run),
    .target(SYS_TARGET),
    .trim_r(sys_trim), // see R5
    .fast_r(sys_fast)
  );

  atoc_trim #(.TRIM_W(atoc_pkg::TRIM_W), .CNT_W(16)) u_tmr_trim (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .osc_edge(tmr_rise),
    .win_end(win_end),
    .run(run),
    .target(TMR_TARGET),
    .trim_r(tmr_trim), // see R6
    .fast_r(tmr_fast)
  );

  // read port
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= '0;
    else if (ce)
    begin
      if (bus.rd)
      begin
        case (bus.addr)
          atoc_pkg::ADDR_INT_DIV: rdata_r <= {div_r, dist_mask_r, 1'b0, int_code_r};
          atoc_pkg::ADDR_TUNE: rdata_r <= tune_r;
          atoc_pkg::ADDR_CAL_STAT: rdata_r <= {cal_ok_r, run, 4'h0, sys_fast, tmr_fast};
          default: rdata_r <= 8'h00;
        endcase
      end
      else
        rdata_r <= 8'h00;
    end
  end

  AST_ANT_ROUTE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && tune_r[7]) |=> irq_pin == $past(div_out)) // see R1
    else $error("antenna display not routed");
  AST_CAP: assert property (@(posedge sys_clk) disable iff (!nrst)
    tune_cap == tune_r[3:0]) // see R2
    else $error("capacitor select mismatch");
  AST_DIV_WR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && bus.wr && bus.addr == 8'h03) |=> div_r == $past(bus.wdata[7:6])) // see R3
    else $error("divider write lost");
  AST_SYS_ROUTE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && tune_r[7:5] == 3'b010) |=> irq_pin == $past(osc.sys)) // see R7
    else $error("system oscillator not routed");
  AST_TMR_ROUTE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && tune_r[7:5] == 3'b001) |=> irq_pin == $past(osc.tmr)) // see R7
    else $error("timer oscillator not routed");
  AST_IRQ_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && event_irq && event_code == 4'h8 && tune_r[7:5] == 3'b000) ##1
    (ce && tune_r[7:5] == 3'b000) |=> irq_pin) // see R12
    else $error("event interrupt not shown");
  AST_IRQ_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && bus.rd && bus.addr == 8'h03 && !event_irq) |=> !irq_r) // see R12
    else $error("interrupt not cleared by read");
  sequence s_cal_start;
    ce && state_r == ST_IDLE && cal_cmd;
  endsequence
  AST_CAL_START: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_cal_start |=> cal_busy && !cal_ok_r) // see R8
    else $error("calibration did not start");
  AST_CAL_RESET: assert property (@(posedge sys_clk)
    $rose(nrst) |-> !cal_ok_r && sys_trim == 7'h40) // see R10
    else $error("calibration survived reset");
endmodule : atoc_top

/* File: bench/atoc_mcu_model.sv */
// far-side model: oscillator sources and the controller's pin period meter
`timescale 1ns/1ps
module atoc_mcu_model #(
  parameter int ANT_HALF = 4,
  parameter int SYS_HALF = 2,
  parameter int TMR_HALF = 8
) (
  // clock
  input wire logic sys_clk,
  // oscillator sources
  output atoc_pkg::atoc_osc_t osc,
  // pin meter
  input wire logic irq_pin,
  output logic [15:0] period
);
  int ant_c = 0;
  int sys_c = 0;
  int tmr_c = 0;
  logic [15:0] cnt = 16'h0000;
  logic pin_d = 1'b0;
  initial osc = '0;
  initial period = 16'h0000;
  // sources count bench clocks so every measured period is exact, with no jitter
  always @(posedge sys_clk)
  begin
    ant_c <= (ant_c == ANT_HALF - 1) ? 0 : ant_c + 1;
    sys_c <= (sys_c == SYS_HALF - 1) ? 0 : sys_c + 1;
    tmr_c <= (tmr_c == TMR_HALF - 1) ? 0 : tmr_c + 1;
    if (ant_c == ANT_HALF - 1) osc.ant <= ~osc.ant;
    if (sys_c == SYS_HALF - 1) osc.sys <= ~osc.sys;
    if (tmr_c == TMR_HALF - 1) osc.tmr <= ~osc.tmr;
  end
  // cycles between rising pin edges, what the controller tunes against
  always @(posedge sys_clk)
  begin
    pin_d <= irq_pin;
    cnt <= cnt + 16'h0001;
    if (irq_pin && !pin_d)
    begin
      period <= cnt + 16'h0001;
      cnt <= 16'h0000;
    end
  end
endmodule : atoc_mcu_model

/* File: bench/tb_atoc_top.sv */
// self-checking bench for the tuning, display routing and calibration block
`timescale 1ns/1ps
module tb_atoc_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  atoc_pkg::atoc_bus_t bus = '0;
  atoc_pkg::atoc_osc_t osc;
  logic event_irq = 1'b0;
  logic [3:0] event_code = 4'h0;
  logic [7:0] rdata_r;
  logic [3:0] tune_cap;
  logic [atoc_pkg::TRIM_W-1:0] sys_trim;
  logic [atoc_pkg::TRIM_W-1:0] tmr_trim;
  logic cal_busy;
  logic irq_pin;
  logic [15:0] period;
  logic [7:0] d;
  logic [7:0] v;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 88;
  int k;
  logic ce = 1'b1;
  logic [3:0] k4 [3] = '{4'h8, 4'h4, 4'h1};
  localparam int STEPS = 4;

  always #2 sys_clk = ~sys_clk;

  atoc_top #(.CAL_WINDOW_CYC(20), .CAL_STEPS(STEPS), .SYS_TARGET(16'h03E8),
    .TMR_TARGET(16'h03E8)) atoc_top_i (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .bus(bus), .rdata_r(rdata_r), .osc(osc), .event_irq(event_irq),
    .event_code(event_code), .tune_cap(tune_cap), .sys_trim(sys_trim),
    .tmr_trim(tmr_trim), .cal_busy(cal_busy), .irq_pin(irq_pin));

  atoc_mcu_model atoc_mcu_model_i (.sys_clk(sys_clk), .osc(osc), .irq_pin(irq_pin),
    .period(period));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 dat = rdata_r;
  endtask : rd

  task pulse(input logic [3:0] c);
    @(posedge sys_clk);
    event_irq <= 1'b1;
    event_code <= c;
    @(posedge sys_clk);
    event_irq <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : pulse

  function automatic logic [15:0] div_period(input int c);
    return 16'(8 * (16 << c));
  endfunction : div_period

  function automatic logic [15:0] trim_dist(input logic [6:0] t);
    return (t > 7'h40) ? 16'(t - 7'h40) : 16'(7'h40 - t);
  endfunction : trim_dist

  task final_report;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report;
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(atoc_pkg::ADDR_TUNE, d);
    chk({8'h00, d}, {8'h00, atoc_pkg::TUNE_RESET});
    rd(atoc_pkg::ADDR_INT_DIV, d);
    chk({8'h00, d}, 16'h0000);
    rd(8'h10, d);
    chk({8'h00, d}, 16'h0000);
    chk(16'(sys_trim), 16'(atoc_pkg::TRIM_MID));
    repeat (8)
    begin
      v = 8'($random(seed)) & 8'h0F;
      wr(atoc_pkg::ADDR_TUNE, v);
      rd(atoc_pkg::ADDR_TUNE, d);
      chk({8'h00, d}, {8'h00, v});
      chk({12'h000, tune_cap}, {8'h00, v});
    end
    // a write while the enable is low must leave the register untouched
    ce <= 1'b0;
    wr(atoc_pkg::ADDR_TUNE, ~v & 8'h0F);
    ce <= 1'b1;
    rd(atoc_pkg::ADDR_TUNE, d);
    chk({8'h00, d}, {8'h00, v});
    for (int c = 0; c < 4; c++)
    begin
      wr(atoc_pkg::ADDR_INT_DIV, 8'(c << atoc_pkg::DIV_LSB));
      wr(atoc_pkg::ADDR_TUNE, 8'h80 | v);
      repeat (3 * div_period(c) + 8) @(posedge sys_clk);
      chk(period, div_period(c));
      chk({12'h000, tune_cap}, {8'h00, v});
    end
    wr(atoc_pkg::ADDR_TUNE, 8'h40);
    repeat (40) @(posedge sys_clk);
    chk(period, 16'h0004);
    wr(atoc_pkg::ADDR_TUNE, 8'h20);
    repeat (80) @(posedge sys_clk);
    chk(period, 16'h0010);
    wr(atoc_pkg::ADDR_TUNE, 8'h00);
    wr(atoc_pkg::ADDR_INT_DIV, 8'h00);
    // each event code raises the pin; reading the register drops it
    foreach (k4[i])
    begin
      pulse(k4[i]);
      chk({15'h0000, irq_pin}, 16'h0001);
      rd(atoc_pkg::ADDR_INT_DIV, d);
      chk({12'h000, d[3:0]}, {12'h000, k4[i]});
      repeat (2) @(posedge sys_clk);
      #1 chk({15'h0000, irq_pin}, 16'h0000);
    end
    wr(atoc_pkg::ADDR_INT_DIV, 8'h20);
    pulse(4'h4);
    chk({15'h0000, irq_pin}, 16'h0000);
    rd(atoc_pkg::ADDR_INT_DIV, d);
    wr(atoc_pkg::ADDR_INT_DIV, 8'h00);
    // a second command during the run must not restart it
    wr(atoc_pkg::ADDR_CAL_CMD, atoc_pkg::CAL_CMD_CODE);
    @(posedge sys_clk);
    #1 chk({15'h0000, cal_busy}, 16'h0001);
    wr(atoc_pkg::ADDR_CAL_CMD, atoc_pkg::CAL_CMD_CODE);
    k = 0;
    while (cal_busy !== 1'b0 && k < 5000)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk({15'h0000, cal_busy}, 16'h0000);
    chk(trim_dist(sys_trim), 16'(STEPS));
    chk(trim_dist(tmr_trim), 16'(STEPS));
    rd(atoc_pkg::ADDR_CAL_STAT, d);
    chk({8'h00, d & 8'hC3}, 16'h0080);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(atoc_pkg::ADDR_CAL_STAT, d);
    chk({8'h00, d & 8'h80}, 16'h0000);
    chk(16'(tmr_trim), 16'(atoc_pkg::TRIM_MID));
    // recovery order: command, timer display on, wait, display off
    wr(atoc_pkg::ADDR_CAL_CMD, atoc_pkg::CAL_CMD_CODE);
    wr(atoc_pkg::ADDR_TUNE, 8'h20);
    k = 0;
    while (cal_busy !== 1'b0 && k < 5000)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk({15'h0000, cal_busy}, 16'h0000);
    chk(period, 16'h0010);
    wr(atoc_pkg::ADDR_TUNE, 8'h00);
    chk(trim_dist(tmr_trim), 16'(STEPS));
    final_report;
  end
endmodule : tb_atoc_top
